// *** blks_defs.vh ***
// constants for the band lock and key select block
`ifndef BLKS_DEFS_VH
`define BLKS_DEFS_VH

// register word offsets
`define BLKS_ADDR_CMD 8'h00
`define BLKS_ADDR_ARG_START 8'h04
`define BLKS_ADDR_ARG_LEN 8'h08
`define BLKS_ADDR_STATUS 8'h0c
`define BLKS_ADDR_BAND_SEL 8'h10
`define BLKS_ADDR_BAND_START 8'h14
`define BLKS_ADDR_BAND_END 8'h18
`define BLKS_ADDR_BAND_FLAGS 8'h1c
`define BLKS_ADDR_CRED_BASE 8'h20
`define BLKS_ADDR_RAND_BASE 8'h40
`define BLKS_ADDR_FDC_BASE 8'h60
`define BLKS_WIN_MASK 8'he3

// command word fields
`define BLKS_CMD_OPC 7:0
`define BLKS_CMD_FN 11:8
`define BLKS_CMD_BAND 16:12
`define BLKS_CMD_AUTH 21:20
`define BLKS_CMD_SA 28:24

// opcodes and service action
`define BLKS_OPC_SEC_OUT 8'hb5
`define BLKS_OPC_SEC_IN 8'ha2
`define BLKS_OPC_SANITIZE 8'h48
`define BLKS_SA_CRYPTO_ERASE 5'h03

// security out functions, security in function
`define BLKS_FN_SET_RANGE 4'h0
`define BLKS_FN_ENABLE_BAND 4'h1
`define BLKS_FN_SET_LOCK 4'h2
`define BLKS_FN_CHANGE_KEY 4'h3
`define BLKS_FN_SET_CRED 4'h4
`define BLKS_FN_FW_ENABLE 4'h5
`define BLKS_FN_REVERT 4'h6
`define BLKS_FN_GET_RANDOM 4'h0

// presented authority
`define BLKS_AUTH_OWNER 2'h0
`define BLKS_AUTH_ERASE 2'h1
`define BLKS_AUTH_RANGE 2'h2
`define BLKS_AUTH_LABEL 2'h3

// status codes
`define BLKS_ST_OK 3'h0
`define BLKS_ST_AUTH 3'h1
`define BLKS_ST_RANGE 3'h2
`define BLKS_ST_NOT_EN 3'h3
`define BLKS_ST_BUSY 3'h4
`define BLKS_ST_BAD_CMD 3'h5

// lock flag bit positions
`define BLKS_LK_RD_GATE 0
`define BLKS_LK_WR_GATE 1
`define BLKS_LK_RELOCK 2
`define BLKS_LK_RD_LOCKED 3
`define BLKS_LK_WR_LOCKED 4

// reset values and sizes (credential values are arbitrary)
`define BLKS_MAX_LBA 32'h0fff_ffff
`define BLKS_FDC_VALUE 256'h5a5a_0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0_1357_9bdf_2468
`define BLKS_LABEL_VALUE 256'hc3c3_1111_2222_3333_4444_5555_6666_7777_8888_9999_aaaa_bbbb_cccc_dddd_eeee_ffff
`define BLKS_LFSR_SEED 32'h0000_0001
`define BLKS_POOL_FRESH 4'h8
`define BLKS_BAND_EN_RST 32'h0000_0003
`define BLKS_BAND_DEF_RST 32'h0000_0001

`endif

// *** blks_band_lock_key_select.v ***
// band lock checking, media key selection and credential gate
// What this block does
// - cipher engine always enabled, fed with the selected band key on every access.
// - media keys made inside from random pool, never readable on the register port.
// - keys live only inside the engine boundary; nothing exports them unwrapped.
// - one unique key per band, 32 bands; access picks the key of its band.
// - every security command without a matching credential is refused.
// - firmware download enable needs owner or factory default credential.
// - lock needs the band's range credential or erase authority credential; erase needs erase authority.
// - owner, erase and band credentials start at factory default value, readable over the register port.
// - hardware random source gives 32-byte values for keys and host requests.
// - power loss locks a band only with relock, read and write gates set.
// - locked band refuses reads or writes until an authorized unlock.
// - firmware download path is open in the factory state.
// - factory state holds only global band 0 covering LBA 0 to maximum.
// - band 1 takes a start and length; those LBAs leave the global band.
// - bands 2 to 31 need erase authority enabling before any LBA allocation.
// - overlapping band definitions are refused; adjacent bands are allowed.
// - key change overwrites the old key and keeps no history.
// - firmware accepted only if self-encrypting, signed and meeting model criteria.
// - security out B5h and security in A2h opcodes are decoded.
// - sanitize 48h service action 3 replaces keys with fresh random ones.
// - factory restore needs label credential, erases all bands, resets all providers.
`timescale 1ns/1ps
`include "blks_defs.vh"

module blks_band_lock_key_select (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// media access lookup
	input wire acc_req,
	input wire [31:0] acc_lba,
	input wire acc_write,
	output reg acc_done,
	output reg acc_grant,
	output reg [4:0] acc_band,
	// inline cipher engine
	output reg eng_enable,
	output reg [255:0] eng_key,
	// firmware download gate
	input wire fw_req,
	input wire fw_is_sed,
	input wire fw_sig_ok,
	input wire fw_criteria_ok,
	output reg fw_done,
	output reg fw_accept,
	output reg fw_dl_open,
	// power loss and entropy
	input wire power_loss_event,
	input wire entropy_in
);

	// band table
	reg [31:0] band_start [0:31];
	reg [31:0] band_end [0:31];
	reg [31:0] band_def;
	reg [31:0] band_en;
	reg [31:0] rd_gate;
	reg [31:0] wr_gate;
	reg [31:0] relock;
	reg [31:0] rd_lk;
	reg [31:0] wr_lk;
	// keys and credentials
	reg [255:0] key_mem [0:31];
	reg [255:0] cred_band [0:31];
	reg [255:0] cred_owner;
	reg [255:0] cred_erase;
	reg [255:0] cred_buf;
	reg [255:0] rand_snap;
	// random source and key walker
	reg [31:0] lfsr;
	reg [255:0] pool;
	reg [3:0] pool_age;
	reg kg_busy;
	reg [4:0] kg_idx;
	// software visible control
	reg [31:0] arg_start;
	reg [31:0] arg_len;
	reg [4:0] band_sel;
	reg [2:0] stat_code;

	// command decode
	wire cmd_wr = reg_wr && (reg_addr == `BLKS_ADDR_CMD);
	wire [7:0] opc = reg_wdata[`BLKS_CMD_OPC];
	wire [3:0] fn = reg_wdata[`BLKS_CMD_FN];
	wire [4:0] cmd_band = reg_wdata[`BLKS_CMD_BAND];
	wire [1:0] auth = reg_wdata[`BLKS_CMD_AUTH];
	wire [4:0] sa = reg_wdata[`BLKS_CMD_SA];
	wire pool_ready = (pool_age == `BLKS_POOL_FRESH);
	wire [32:0] new_end = {1'b0, arg_start} + {1'b0, arg_len} - 33'h000000001;
	wire range_bad = (arg_len != 32'h0) && (new_end > {1'b0, `BLKS_MAX_LBA});
	wire [31:0] blk_mask = relock & rd_gate & wr_gate;
	wire [255:0] fdc_value = `BLKS_FDC_VALUE;

	// per band overlap and address match
	wire [31:0] ovl;
	wire [31:0] hit;
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_band
			localparam integer IDX = gi;
			// band 0 is the remainder, so it never blocks a new range; an empty range overlaps nothing
			assign ovl[gi] = (IDX != 0) && band_def[gi] && (cmd_band != IDX[4:0]) && (arg_len != 32'h0)
				&& (arg_start <= band_end[gi]) && (new_end[31:0] >= band_start[gi]);
			assign hit[gi] = (IDX != 0) && band_def[gi]
				&& (acc_lba >= band_start[gi]) && (acc_lba <= band_end[gi]);
		end
	endgenerate

	// lowest numbered matching band, else global band
	reg [4:0] hit_idx;
	integer k;
	always @* begin
		hit_idx = 5'h00;
		for (k = 31; k > 0; k = k - 1) begin
			if (hit[k]) begin
				hit_idx = k[4:0];
			end
		end
	end

	// credential compare for the presented authority
	reg cred_ok;
	always @* begin
		case (auth)
			`BLKS_AUTH_OWNER: cred_ok = (cred_buf == cred_owner) || (cred_buf == fdc_value);
			`BLKS_AUTH_ERASE: cred_ok = (cred_buf == cred_erase);
			`BLKS_AUTH_RANGE: cred_ok = (cred_buf == cred_band[cmd_band]);
			`BLKS_AUTH_LABEL: cred_ok = (cred_buf == `BLKS_LABEL_VALUE);
			default: cred_ok = 1'b0;
		endcase
	end
	wire lock_ok = cred_ok && ((auth == `BLKS_AUTH_RANGE) || (auth == `BLKS_AUTH_ERASE));
	wire erase_ok = cred_ok && (auth == `BLKS_AUTH_ERASE);

	// command validation, one result per command write
	reg do_range;
	reg do_enable;
	reg do_lock;
	reg do_key;
	reg do_cred;
	reg do_fw;
	reg do_revert;
	reg do_wipe;
	reg do_rand;
	reg [2:0] st_next;
	always @* begin
		do_range = 1'b0;
		do_enable = 1'b0;
		do_lock = 1'b0;
		do_key = 1'b0;
		do_cred = 1'b0;
		do_fw = 1'b0;
		do_revert = 1'b0;
		do_wipe = 1'b0;
		do_rand = 1'b0;
		st_next = `BLKS_ST_OK;
		if (kg_busy) begin
			st_next = `BLKS_ST_BUSY;
		end else begin
			case (opc)
				`BLKS_OPC_SEC_OUT: begin
					case (fn)
						`BLKS_FN_SET_RANGE: begin
							if (!lock_ok)
								st_next = `BLKS_ST_AUTH;
							else if ((cmd_band == 5'h00) || !band_en[cmd_band])
								st_next = `BLKS_ST_NOT_EN;
							else if (range_bad || (|ovl))
								st_next = `BLKS_ST_RANGE;
							else
								do_range = 1'b1;
						end
						`BLKS_FN_ENABLE_BAND: begin
							if (!erase_ok)
								st_next = `BLKS_ST_AUTH;
							else if (cmd_band < 5'h02)
								st_next = `BLKS_ST_BAD_CMD;
							else
								do_enable = 1'b1;
						end
						`BLKS_FN_SET_LOCK: begin
							if (lock_ok)
								do_lock = 1'b1;
							else
								st_next = `BLKS_ST_AUTH;
						end
						`BLKS_FN_CHANGE_KEY: begin
							if (!lock_ok)
								st_next = `BLKS_ST_AUTH;
							else if (!pool_ready)
								st_next = `BLKS_ST_BUSY;
							else
								do_key = 1'b1;
						end
						`BLKS_FN_SET_CRED: begin
							if (auth == `BLKS_AUTH_LABEL)
								st_next = `BLKS_ST_BAD_CMD;
							else if (!cred_ok)
								st_next = `BLKS_ST_AUTH;
							else
								do_cred = 1'b1;
						end
						`BLKS_FN_FW_ENABLE: begin
							if (cred_ok && (auth == `BLKS_AUTH_OWNER))
								do_fw = 1'b1;
							else
								st_next = `BLKS_ST_AUTH;
						end
						`BLKS_FN_REVERT: begin
							if (cred_ok && (auth == `BLKS_AUTH_LABEL))
								do_revert = 1'b1;
							else
								st_next = `BLKS_ST_AUTH;
						end
						default: st_next = `BLKS_ST_BAD_CMD;
					endcase
				end
				`BLKS_OPC_SEC_IN: begin
					if (fn != `BLKS_FN_GET_RANDOM)
						st_next = `BLKS_ST_BAD_CMD;
					else if (!cred_ok || (auth == `BLKS_AUTH_LABEL))
						st_next = `BLKS_ST_AUTH;
					else if (!pool_ready)
						st_next = `BLKS_ST_BUSY;
					else
						do_rand = 1'b1;
				end
				`BLKS_OPC_SANITIZE: begin
					if (sa != `BLKS_SA_CRYPTO_ERASE)
						st_next = `BLKS_ST_BAD_CMD;
					else if (erase_ok)
						do_wipe = 1'b1;
					else
						st_next = `BLKS_ST_AUTH;
				end
				default: st_next = `BLKS_ST_BAD_CMD;
			endcase
		end
	end

	wire take_key = cmd_wr && do_key;
	wire take_rand = cmd_wr && do_rand;
	wire walk_step = kg_busy && pool_ready;
	wire walk_start = cmd_wr && (do_wipe || do_revert);

	// random source: lfsr stirred by entropy, pool refilled 32 bits a cycle
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lfsr <= `BLKS_LFSR_SEED;
			pool <= 256'h0;
			pool_age <= 4'h0;
		end else begin
			lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0] ^ entropy_in};
			pool <= {pool[223:0], lfsr};
			// a taken pool is never reused, so keys and host values stay distinct
			if (take_key || take_rand || walk_step)
				pool_age <= 4'h0;
			else if (!pool_ready)
				pool_age <= pool_age + 4'h1;
		end
	end

	// key store and walker that regenerates every key in turn
	integer m;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (m = 0; m < 32; m = m + 1)
				key_mem[m] <= 256'h0;
			kg_busy <= 1'b1;
			kg_idx <= 5'h00;
			rand_snap <= 256'h0;
		end else begin
			if (walk_start) begin
				kg_busy <= 1'b1;
				kg_idx <= 5'h00;
			end else if (walk_step) begin
				key_mem[kg_idx] <= pool;
				kg_idx <= kg_idx + 5'h01;
				if (kg_idx == 5'h1f)
					kg_busy <= 1'b0;
			end
			// old key is overwritten in place, no copy kept
			if (take_key)
				key_mem[cmd_band] <= pool;
			if (take_rand)
				rand_snap <= pool;
		end
	end

	// band table, credentials and command status
	integer n;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (n = 0; n < 32; n = n + 1) begin
				band_start[n] <= 32'h0;
				band_end[n] <= 32'h0;
				cred_band[n] <= `BLKS_FDC_VALUE;
			end
			band_end[0] <= `BLKS_MAX_LBA;
			band_def <= `BLKS_BAND_DEF_RST;
			band_en <= `BLKS_BAND_EN_RST;
			rd_gate <= 32'h0;
			wr_gate <= 32'h0;
			relock <= 32'h0;
			rd_lk <= 32'h0;
			wr_lk <= 32'h0;
			cred_owner <= `BLKS_FDC_VALUE;
			cred_erase <= `BLKS_FDC_VALUE;
			cred_buf <= 256'h0;
			fw_dl_open <= 1'b1;
			arg_start <= 32'h0;
			arg_len <= 32'h0;
			band_sel <= 5'h00;
			stat_code <= `BLKS_ST_OK;
		end else begin
			// plain register writes
			if (reg_wr && (reg_addr == `BLKS_ADDR_ARG_START))
				arg_start <= reg_wdata;
			if (reg_wr && (reg_addr == `BLKS_ADDR_ARG_LEN))
				arg_len <= reg_wdata;
			if (reg_wr && (reg_addr == `BLKS_ADDR_BAND_SEL))
				band_sel <= reg_wdata[4:0];
			if (reg_wr && ((reg_addr & `BLKS_WIN_MASK) == `BLKS_ADDR_CRED_BASE))
				cred_buf[{reg_addr[4:2], 5'h00} +: 32] <= reg_wdata;
			if (cmd_wr) begin
				stat_code <= st_next;
				// presented credential is spent by every command
				cred_buf <= 256'h0;
			end
			if (cmd_wr && do_range) begin
				band_start[cmd_band] <= arg_start;
				band_end[cmd_band] <= new_end[31:0];
				band_def[cmd_band] <= (arg_len != 32'h0);
			end
			if (cmd_wr && do_enable)
				band_en[cmd_band] <= 1'b1;
			if (cmd_wr && do_lock) begin
				rd_gate[cmd_band] <= arg_start[`BLKS_LK_RD_GATE];
				wr_gate[cmd_band] <= arg_start[`BLKS_LK_WR_GATE];
				relock[cmd_band] <= arg_start[`BLKS_LK_RELOCK];
				rd_lk[cmd_band] <= arg_start[`BLKS_LK_RD_LOCKED];
				wr_lk[cmd_band] <= arg_start[`BLKS_LK_WR_LOCKED];
			end
			if (cmd_wr && do_cred) begin
				// new credential is the last random value handed to the host
				case (auth)
					`BLKS_AUTH_OWNER: cred_owner <= rand_snap;
					`BLKS_AUTH_ERASE: cred_erase <= rand_snap;
					default: cred_band[cmd_band] <= rand_snap;
				endcase
			end
			if (cmd_wr && do_fw)
				fw_dl_open <= arg_start[0];
			if (cmd_wr && do_revert) begin
				for (n = 1; n < 32; n = n + 1)
					band_end[n] <= 32'h0;
				for (n = 0; n < 32; n = n + 1)
					cred_band[n] <= `BLKS_FDC_VALUE;
				band_def <= `BLKS_BAND_DEF_RST;
				band_en <= `BLKS_BAND_EN_RST;
				rd_gate <= 32'h0;
				wr_gate <= 32'h0;
				relock <= 32'h0;
				rd_lk <= 32'h0;
				wr_lk <= 32'h0;
				cred_owner <= `BLKS_FDC_VALUE;
				cred_erase <= `BLKS_FDC_VALUE;
				fw_dl_open <= 1'b1;
			end
			// power loss comes last so it wins over a same cycle unlock
			if (power_loss_event) begin
				rd_lk <= rd_lk | blk_mask;
				wr_lk <= wr_lk | blk_mask;
			end
		end
	end

	// access check, key select and engine feed
	wire rd_block = rd_gate[hit_idx] && rd_lk[hit_idx];
	wire wr_block = wr_gate[hit_idx] && wr_lk[hit_idx];
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_done <= 1'b0;
			acc_grant <= 1'b0;
			acc_band <= 5'h00;
			eng_enable <= 1'b1;
			eng_key <= 256'h0;
		end else begin
			acc_done <= acc_req;
			eng_enable <= 1'b1;
			if (acc_req) begin
				acc_band <= hit_idx;
				// keys are not valid while the walker rewrites them
				acc_grant <= !kg_busy && !(acc_write ? wr_block : rd_block);
				eng_key <= key_mem[hit_idx];
			end else begin
				acc_grant <= 1'b0;
			end
		end
	end

	// firmware download acceptance
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fw_done <= 1'b0;
			fw_accept <= 1'b0;
		end else begin
			fw_done <= fw_req;
			fw_accept <= fw_req && fw_dl_open && fw_is_sed && fw_sig_ok && fw_criteria_ok;
		end
	end

	// read mux; credentials and keys have no read path
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0;
		if ((reg_addr & `BLKS_WIN_MASK) == `BLKS_ADDR_RAND_BASE)
			rd_mux = rand_snap[{reg_addr[4:2], 5'h00} +: 32];
		else if ((reg_addr & `BLKS_WIN_MASK) == `BLKS_ADDR_FDC_BASE)
			rd_mux = fdc_value[{reg_addr[4:2], 5'h00} +: 32];
		else begin
			case (reg_addr)
				`BLKS_ADDR_ARG_START: rd_mux = arg_start;
				`BLKS_ADDR_ARG_LEN: rd_mux = arg_len;
				`BLKS_ADDR_STATUS: rd_mux = {27'h0, fw_dl_open, kg_busy, stat_code};
				`BLKS_ADDR_BAND_SEL: rd_mux = {27'h0, band_sel};
				`BLKS_ADDR_BAND_START: rd_mux = band_start[band_sel];
				`BLKS_ADDR_BAND_END: rd_mux = band_end[band_sel];
				`BLKS_ADDR_BAND_FLAGS: rd_mux = {25'h0, band_def[band_sel], band_en[band_sel],
					wr_lk[band_sel], rd_lk[band_sel], relock[band_sel], wr_gate[band_sel], rd_gate[band_sel]};
				default: rd_mux = 32'h0;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= 32'h0;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 32'h0;
	end

endmodule // blks_band_lock_key_select

// *** blks_band_lock_key_select_sva.sv ***
// assertion checker for the band lock and key select block
`timescale 1ns/1ps
`include "blks_defs.vh"

module blks_band_lock_key_select_sva (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// register port
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// access lookup and engine
	input wire acc_req,
	input wire acc_done,
	input wire acc_grant,
	input wire [4:0] acc_band,
	input wire eng_enable,
	// firmware gate
	input wire fw_req,
	input wire fw_is_sed,
	input wire fw_sig_ok,
	input wire fw_criteria_ok,
	input wire fw_done,
	input wire fw_accept,
	input wire fw_dl_open
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// lookup steps: a lone request, then a lone answer
	sequence s_req_once;
		acc_req ##1 !acc_req;
	endsequence
	sequence s_done_once;
		acc_done ##1 !acc_done;
	endsequence
	// an image that must be taken
	sequence s_fw_good;
		fw_req && fw_dl_open && fw_is_sed && fw_sig_ok && fw_criteria_ok;
	endsequence

	a_engine_on: assert property (eng_enable)
		else $error("cipher engine off");
	a_lookup_pulse: assert property (s_req_once |-> s_done_once)
		else $error("lookup answer not one cycle");
	a_no_stray_grant: assert property (!acc_req |=> !acc_done && !acc_grant)
		else $error("answer without request");
	a_band_holds: assert property (!acc_req |=> $stable(acc_band))
		else $error("band changed without request");
	a_fw_taken: assert property (s_fw_good |=> fw_done && fw_accept)
		else $error("good image refused");
	a_fw_refused: assert property (fw_req && !(fw_dl_open && fw_is_sed && fw_sig_ok && fw_criteria_ok)
		|=> fw_done && !fw_accept)
		else $error("bad image taken");
	a_fw_quiet: assert property (!fw_req |=> !fw_done && !fw_accept)
		else $error("image answer without request");
	// secrets and idle cycles must read back as zero
	a_rdata_hidden: assert property ((!reg_rd || reg_addr[7] || reg_addr[7:5] == 3'h1
		|| reg_addr == `BLKS_ADDR_CMD) |=> reg_rdata == 32'h0)
		else $error("read data where none allowed");
	a_dl_by_write: assert property ($changed(fw_dl_open) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("download gate moved without command");
endmodule // blks_band_lock_key_select_sva

bind blks_band_lock_key_select blks_band_lock_key_select_sva blks_band_lock_key_select_sva_i (
	.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .acc_req, .acc_done, .acc_grant,
	.acc_band, .eng_enable, .fw_req, .fw_is_sed, .fw_sig_ok, .fw_criteria_ok, .fw_done,
	.fw_accept, .fw_dl_open);

// *** blks_host_model.sv ***
// far-side requester model: media lookups and firmware image checks
`timescale 1ns/1ps

module blks_host_model (
	// clock
	input wire clk,
	// media lookup
	output reg acc_req,
	output reg [31:0] acc_lba,
	output reg acc_write,
	// firmware image check
	output reg fw_req,
	output reg fw_is_sed,
	output reg fw_sig_ok,
	output reg fw_criteria_ok
);
	// idle at time zero
	initial begin
		acc_req = 1'b0;
		acc_lba = 32'h0;
		acc_write = 1'b0;
		fw_req = 1'b0;
		{fw_is_sed, fw_sig_ok, fw_criteria_ok} = 3'h0;
	end

	// released qualifiers are inverted so a stale value is never trusted
	task access(input [31:0] lba, input wr);
		begin
			@(posedge clk);
			acc_req <= 1'b1;
			acc_lba <= lba;
			acc_write <= wr;
			@(posedge clk);
			acc_req <= 1'b0;
			acc_lba <= ~lba;
			acc_write <= ~wr;
			#1;
		end
	endtask

	// flags are {self-encrypting, signed, criteria}
	task fw_check(input [2:0] f);
		begin
			@(posedge clk);
			fw_req <= 1'b1;
			{fw_is_sed, fw_sig_ok, fw_criteria_ok} <= f;
			@(posedge clk);
			fw_req <= 1'b0;
			{fw_is_sed, fw_sig_ok, fw_criteria_ok} <= ~f;
			#1;
		end
	endtask
endmodule // blks_host_model

// *** blks_band_lock_key_select_tb.sv ***
// self-checking testbench for the band lock and key select block
`timescale 1ns/1ps
`include "blks_defs.vh"

module blks_band_lock_key_select_tb;
	localparam [255:0] FDC = `BLKS_FDC_VALUE;
	localparam [255:0] LBL = `BLKS_LABEL_VALUE;
	reg clk, sys_rst, reg_wr, reg_rd, power_loss_event, entropy_in;
	reg [7:0] reg_addr;
	reg [31:0] reg_wdata;
	wire [31:0] reg_rdata, acc_lba;
	wire acc_req, acc_write, acc_done, acc_grant, eng_enable;
	wire fw_req, fw_is_sed, fw_sig_ok, fw_criteria_ok, fw_done, fw_accept, fw_dl_open;
	wire [4:0] acc_band;
	wire [255:0] eng_key;
	integer n_mismatch, compares, i, j;
	reg [31:0] rv;
	reg [255:0] k0, k1;

	blks_band_lock_key_select blks_band_lock_key_select_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .acc_req, .acc_lba, .acc_write, .acc_done, .acc_grant, .acc_band, .eng_enable,
		.eng_key, .fw_req, .fw_is_sed, .fw_sig_ok, .fw_criteria_ok, .fw_done, .fw_accept, .fw_dl_open,
		.power_loss_event, .entropy_in);
	blks_host_model blks_host_model_i (.clk, .acc_req, .acc_lba, .acc_write, .fw_req, .fw_is_sed,
		.fw_sig_ok, .fw_criteria_ok);

	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// keep the entropy input moving
	always @(posedge clk) entropy_in <= ~entropy_in;

	task print_verdict;
		begin
			$display("compares=%0d mismatches=%0d", compares, n_mismatch);
			if (n_mismatch == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// register port: one-cycle strobes, read data the cycle after
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 rv = reg_rdata;
		end
	endtask
	task rdc(input [7:0] a, input [31:0] e);
		begin
			rd(a);
			chk(rv, e);
		end
	endtask
	// credential, argument, command, then status code
	task sec(input [255:0] c, input [31:0] arg, input [7:0] op, input [3:0] fn, input [4:0] b, input [1:0] au,
		input [2:0] e);
		begin
			for (i = 0; i < 8; i = i + 1)
				wr(`BLKS_ADDR_CRED_BASE + {i[5:0], 2'h0}, c[32 * i +: 32]);
			wr(`BLKS_ADDR_ARG_START, arg);
			wr(`BLKS_ADDR_CMD, {3'h0, (op == `BLKS_OPC_SANITIZE) ? `BLKS_SA_CRYPTO_ERASE : 5'h0, 2'h0, au,
				3'h0, b, fn, op});
			rd(`BLKS_ADDR_STATUS);
			chk({29'h0, rv[2:0]}, {29'h0, e});
		end
	endtask
	// the walker can run hundreds of cycles; bounded poll
	task wait_idle;
		begin
			rv = 32'h8;
			for (j = 0; j < 1000 && rv[3] !== 1'b0; j = j + 1)
				rd(`BLKS_ADDR_STATUS);
			if (j >= 1000) begin
				n_mismatch = n_mismatch + 1;
				print_verdict;
			end
		end
	endtask
	task look(input [31:0] lba, input w, input [4:0] b, input g);
		begin
			blks_host_model_i.access(lba, w);
			chk({26'h0, acc_done, acc_grant, acc_band}, {26'h0, 1'b1, g, b});
		end
	endtask
	task fwc(input [2:0] f, input e);
		begin
			blks_host_model_i.fw_check(f);
			chk({30'h0, fw_done, fw_accept}, {30'h0, 1'b1, e});
		end
	endtask

	initial begin
		n_mismatch = 0;
		compares = 0;
		sys_rst = 1'b1;
		{reg_wr, reg_rd, power_loss_event, entropy_in} = 4'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		wait_idle;
		// factory state
		rdc(`BLKS_ADDR_STATUS, 32'h10);
		for (j = 0; j < 8; j = j + 1)
			rdc(`BLKS_ADDR_FDC_BASE + {j[5:0], 2'h0}, FDC[32 * j +: 32]);
		rdc(8'h80, 32'h0);
		wr(`BLKS_ADDR_BAND_SEL, 32'h0);
		rdc(`BLKS_ADDR_BAND_END, `BLKS_MAX_LBA);
		look(`BLKS_MAX_LBA, 1'b1, 5'h0, 1'b1);
		chk({31'h0, eng_enable}, 32'h1);
		$display("test factory state done");
		// band allocation, 4K aligned edges
		wr(`BLKS_ADDR_ARG_LEN, 32'h1000);
		sec(256'h0, 32'h1000, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_RANGE, 5'h1, `BLKS_AUTH_ERASE, `BLKS_ST_AUTH);
		sec(FDC, 32'h1000, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_RANGE, 5'h1, `BLKS_AUTH_ERASE, `BLKS_ST_OK);
		look(32'h0fff, 1'b0, 5'h0, 1'b1);
		look(32'h1000, 1'b0, 5'h1, 1'b1);
		look(32'h1fff, 1'b1, 5'h1, 1'b1);
		look(32'h2000, 1'b0, 5'h0, 1'b1);
		sec(FDC, 32'h2000, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_RANGE, 5'h2, `BLKS_AUTH_ERASE, `BLKS_ST_NOT_EN);
		sec(FDC, 32'h0, `BLKS_OPC_SEC_OUT, `BLKS_FN_ENABLE_BAND, 5'h2, `BLKS_AUTH_ERASE, `BLKS_ST_OK);
		sec(FDC, 32'h1800, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_RANGE, 5'h2, `BLKS_AUTH_ERASE, `BLKS_ST_RANGE);
		sec(FDC, 32'h2000, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_RANGE, 5'h2, `BLKS_AUTH_ERASE, `BLKS_ST_OK);
		look(32'h2000, 1'b0, 5'h2, 1'b1);
		$display("test bands done");
		// relock on power loss needs relock and both gates
		sec(FDC, 32'h7, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_LOCK, 5'h1, `BLKS_AUTH_ERASE, `BLKS_ST_OK);
		sec(FDC, 32'h5, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_LOCK, 5'h2, `BLKS_AUTH_RANGE, `BLKS_ST_OK);
		look(32'h1000, 1'b1, 5'h1, 1'b1);
		@(posedge clk) power_loss_event <= 1'b1;
		@(posedge clk) power_loss_event <= 1'b0;
		look(32'h1000, 1'b0, 5'h1, 1'b0);
		look(32'h1fff, 1'b1, 5'h1, 1'b0);
		look(32'h2000, 1'b0, 5'h2, 1'b1);
		wr(`BLKS_ADDR_BAND_SEL, 32'h1);
		rdc(`BLKS_ADDR_BAND_FLAGS, 32'h7f);
		sec(FDC, 32'h7, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_LOCK, 5'h1, `BLKS_AUTH_RANGE, `BLKS_ST_OK);
		look(32'h1000, 1'b0, 5'h1, 1'b1);
		$display("test locking done");
		// per-band keys, key change, random source, opcodes, sanitize
		look(32'h0, 1'b0, 5'h0, 1'b1);
		k0 = eng_key;
		look(32'h1000, 1'b0, 5'h1, 1'b1);
		k1 = eng_key;
		chk({31'h0, k0 !== k1}, 32'h1);
		repeat (10) @(posedge clk);
		sec(FDC, 32'h0, `BLKS_OPC_SEC_OUT, `BLKS_FN_CHANGE_KEY, 5'h1, `BLKS_AUTH_ERASE, `BLKS_ST_OK);
		look(32'h1000, 1'b0, 5'h1, 1'b1);
		chk({31'h0, eng_key !== k1}, 32'h1);
		sec(FDC, 32'h0, `BLKS_OPC_SEC_IN, `BLKS_FN_GET_RANDOM, 5'h0, `BLKS_AUTH_OWNER, `BLKS_ST_OK);
		rd(`BLKS_ADDR_RAND_BASE);
		chk({31'h0, rv !== 32'h0}, 32'h1);
		sec(256'h0, 32'h0, `BLKS_OPC_SEC_IN, `BLKS_FN_GET_RANDOM, 5'h0, `BLKS_AUTH_OWNER, `BLKS_ST_AUTH);
		// the random value becomes band 2's credential; the factory value must then fail
		for (j = 0; j < 8; j = j + 1) begin
			rd(`BLKS_ADDR_RAND_BASE + {j[5:0], 2'h0});
			k1[32 * j +: 32] = rv;
		end
		sec(FDC, 32'h5, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_CRED, 5'h2, `BLKS_AUTH_RANGE, `BLKS_ST_OK);
		sec(FDC, 32'h5, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_LOCK, 5'h2, `BLKS_AUTH_RANGE, `BLKS_ST_AUTH);
		sec(k1, 32'h5, `BLKS_OPC_SEC_OUT, `BLKS_FN_SET_LOCK, 5'h2, `BLKS_AUTH_RANGE, `BLKS_ST_OK);
		sec(FDC, 32'h0, 8'h11, 4'h0, 5'h0, `BLKS_AUTH_OWNER, `BLKS_ST_BAD_CMD);
		sec(FDC, 32'h0, `BLKS_OPC_SANITIZE, 4'h0, 5'h0, `BLKS_AUTH_ERASE, `BLKS_ST_OK);
		wait_idle;
		look(32'h0, 1'b0, 5'h0, 1'b1);
		chk({31'h0, eng_key !== k0}, 32'h1);
		$display("test keys done");
		// firmware gate: all three conditions, then the owner switch
		fwc(3'h7, 1'b1);
		for (j = 0; j < 7; j = j + 1)
			fwc(j[2:0], 1'b0);
		sec(256'h0, 32'h0, `BLKS_OPC_SEC_OUT, `BLKS_FN_FW_ENABLE, 5'h0, `BLKS_AUTH_OWNER, `BLKS_ST_AUTH);
		sec(FDC, 32'h0, `BLKS_OPC_SEC_OUT, `BLKS_FN_FW_ENABLE, 5'h0, `BLKS_AUTH_OWNER, `BLKS_ST_OK);
		rdc(`BLKS_ADDR_STATUS, 32'h0);
		fwc(3'h7, 1'b0);
		$display("test firmware done");
		// factory restore only with the label value
		sec(FDC, 32'h0, `BLKS_OPC_SEC_OUT, `BLKS_FN_REVERT, 5'h0, `BLKS_AUTH_LABEL, `BLKS_ST_AUTH);
		sec(LBL, 32'h0, `BLKS_OPC_SEC_OUT, `BLKS_FN_REVERT, 5'h0, `BLKS_AUTH_LABEL, `BLKS_ST_OK);
		wait_idle;
		rdc(`BLKS_ADDR_STATUS, 32'h10);
		look(32'h1000, 1'b0, 5'h0, 1'b1);
		$display("test restore done");
		print_verdict;
	end
endmodule // blks_band_lock_key_select_tb
